// *** common/rtc_pit_regs.vh ***
// Purpose: Offsets, fields, resets and counts of the real-time counter.
// Assumes: Byte registers on a strobe port.
// Notes: Offsets are byte addresses.
`ifndef RTC_PIT_REGS_VH
`define RTC_PIT_REGS_VH

`define OFF_COUNTER_CONTROL      5'h00
`define OFF_SYNC_STATUS          5'h01
`define OFF_COUNTER_IRQ_ENABLES  5'h02
`define OFF_COUNTER_IRQ_FLAGS    5'h03
`define OFF_COUNTER_DEBUG        5'h05
`define OFF_COUNT_LO             5'h08
`define OFF_COUNT_HI             5'h09
`define OFF_PERIOD_LO            5'h0A
`define OFF_PERIOD_HI            5'h0B
`define OFF_COMPARE_LO           5'h0C
`define OFF_COMPARE_HI           5'h0D
`define OFF_PERIODIC_CONTROL     5'h10
`define OFF_PERIODIC_SYNC_STATUS 5'h11
`define OFF_PERIODIC_IRQ_ENABLES 5'h12
`define OFF_PERIODIC_IRQ_FLAGS   5'h13
`define OFF_PERIODIC_DEBUG       5'h15

`define BIT_ENABLE          0
`define BIT_RUN_IN_STANDBY  7
`define FLD_PRESCALER_LSB   3
`define FLD_PERIOD_LSB      3
`define BIT_OVERFLOW        0
`define BIT_COMPARE         1

`define RESET_PERIOD_VALUE  16'hFFFF
`define RESET_BYTE          8'h00

// Real-time edges a write takes to land
`define SYNC_RTC_CYCLES     2
// Periodic select code clamp
`define PIT_CODE_MIN        4'h1
`define PIT_CODE_MAX        4'hE

`endif

// *** rtl/rtc_periodic_interrupt_timer.v ***
// Purpose: Real-time counter and periodic interrupt timer sharing one prescaler.
// Assumes: Real-time clock is a slow pin sampled by sys_clk_i.
// Notes: Byte registers; read data one cycle after the strobe.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`include "rtc_pit_regs.vh"
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1: Counter runs while its enable bit is one.
// R2: Periodic timer runs on its own enable bit.
// R3: One shared prescaler, clocked by the real-time clock.
// R4: Prescaler stops when both enables are zero, counts otherwise.
// R5: First tick or periodic interrupt comes within one period.
// R6: After first interrupt, periodic output toggles every half period.
// R7: Events last one real-time period, on the flag conditions.
// R8: Overflow when counter reached period value and wraps to zero.
// R9: Compare when counter equals compare value.
// R10: Periodic interrupt each time selected interval elapses.
// R11: Each condition sets its own flag; two separate flag registers.
// R12: Request stands while enable and flag set, until flag cleared.
// R13: Software configures all before enabling the counter.
// R14: Counter runs in idle sleep; in standby only with run-in-standby.
// R15: Periodic timer runs in every sleep mode.
// R16: Control and count writes land after a synchronization delay.
// R17: Busy bits show compare, period, count or control synchronizing.
// R18: Busy bit reads one while periodic control synchronizes.
// R19: Software checks busy clear before writing synchronized registers.
// R20: Debug halt without debug-run stops counter, ignores events.
// R21: Debug halt without periodic debug-run forces output low.
// R22: Output high at halt gives extra rise and interrupt on restart.
// R23: Flags raise on first count after equality; overflow zeroes count.
// R24: Periodic interval is powers of two, 4 to 32768 cycles.
// R25: Prescaler divides by two to the field value, up to 32768.
// R26: Prescaler update acts two real-time cycles after the write.
// R27: Counter increments once per prescaled tick, holds while disabled.
module rtc_periodic_interrupt_timer #(
    parameter PRESCALE_BITS = 15
) (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire rtc_clk_pin_i,
    input wire [4:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire idle_sleep_i,
    input wire standby_sleep_i,
    input wire debug_halt_i,
    output reg [7:0] rdata_o,
    output wire counter_irq_o,
    output wire periodic_irq_o,
    output reg overflow_event_o,
    output reg compare_event_o,
    output reg periodic_out_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Real-time clock pin sampling

    reg [2:0] rtc_sync;
    reg rtc_level;
    wire rtc_edge;

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rtc_sync <= 3'h0;
            rtc_level <= 1'b0;
        end else begin
            rtc_sync <= {rtc_sync[1:0], rtc_clk_pin_i};
            if (rtc_sync[1] == rtc_sync[2])
                rtc_level <= rtc_sync[2];
        end
    end

    // One strobe per rising real-time clock edge
    assign rtc_edge = (rtc_sync[1] == rtc_sync[2]) && rtc_sync[2] && !rtc_level;

    ////////////////////////////////////////////////////////////////////////////
    // Software-side registers

    reg counter_enable;
    reg run_in_standby;
    reg [3:0] prescaler_sel;
    reg [1:0] counter_irq_enables;
    reg [1:0] counter_irq_flags;
    reg counter_debug_run;
    reg [15:0] count_shadow;
    reg [15:0] period_shadow;
    reg [15:0] compare_shadow;
    reg periodic_timer_enable;
    reg [3:0] periodic_sel;
    reg periodic_irq_enable;
    reg periodic_irq_flag;
    reg periodic_debug_run;
    reg [7:0] count_hi_latch;

    // Busy: {compare, period, count, control, periodic control}
    reg [4:0] sync_pend;
    reg [1:0] sync_age;

    // Real-time domain copies
    reg rt_counter_enable;
    reg rt_run_in_standby;
    reg [3:0] rt_prescaler_sel;
    reg [15:0] rt_period;
    reg [15:0] rt_compare;
    reg rt_periodic_enable;
    reg [3:0] rt_periodic_sel;
    reg [15:0] count_value;

    wire hit_ctrl = wr_i && (addr_i == `OFF_COUNTER_CONTROL);
    wire hit_pctrl = wr_i && (addr_i == `OFF_PERIODIC_CONTROL);
    wire hit_cnt = wr_i && (addr_i == `OFF_COUNT_LO || addr_i == `OFF_COUNT_HI);
    wire hit_per = wr_i && (addr_i == `OFF_PERIOD_LO || addr_i == `OFF_PERIOD_HI);
    wire hit_cmp = wr_i && (addr_i == `OFF_COMPARE_LO || addr_i == `OFF_COMPARE_HI);

    wire overflow_hit;
    wire compare_hit;
    wire periodic_rise;

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            counter_enable <= 1'b0;
            run_in_standby <= 1'b0;
            prescaler_sel <= 4'h0;
            counter_irq_enables <= 2'h0;
            counter_irq_flags <= 2'h0;
            counter_debug_run <= 1'b0;
            count_shadow <= 16'h0000;
            period_shadow <= `RESET_PERIOD_VALUE;
            compare_shadow <= 16'h0000;
            periodic_timer_enable <= 1'b0;
            periodic_sel <= 4'h0;
            periodic_irq_enable <= 1'b0;
            periodic_irq_flag <= 1'b0;
            periodic_debug_run <= 1'b0;
        end else begin
            if (hit_ctrl) begin
                counter_enable <= wdata_i[`BIT_ENABLE];
                run_in_standby <= wdata_i[`BIT_RUN_IN_STANDBY];
                prescaler_sel <= wdata_i[`FLD_PRESCALER_LSB+3:`FLD_PRESCALER_LSB];
            end
            if (hit_pctrl) begin
                periodic_timer_enable <= wdata_i[`BIT_ENABLE];
                periodic_sel <= wdata_i[`FLD_PERIOD_LSB+3:`FLD_PERIOD_LSB];
            end
            if (wr_i && addr_i == `OFF_COUNTER_IRQ_ENABLES)
                counter_irq_enables <= wdata_i[1:0];
            if (wr_i && addr_i == `OFF_COUNTER_DEBUG)
                counter_debug_run <= wdata_i[0];
            if (wr_i && addr_i == `OFF_PERIODIC_IRQ_ENABLES)
                periodic_irq_enable <= wdata_i[0];
            if (wr_i && addr_i == `OFF_PERIODIC_DEBUG)
                periodic_debug_run <= wdata_i[0];
            if (wr_i && addr_i == `OFF_COUNT_LO)
                count_shadow[7:0] <= wdata_i;
            if (wr_i && addr_i == `OFF_COUNT_HI)
                count_shadow[15:8] <= wdata_i;
            if (wr_i && addr_i == `OFF_PERIOD_LO)
                period_shadow[7:0] <= wdata_i;
            if (wr_i && addr_i == `OFF_PERIOD_HI)
                period_shadow[15:8] <= wdata_i;
            if (wr_i && addr_i == `OFF_COMPARE_LO)
                compare_shadow[7:0] <= wdata_i;
            if (wr_i && addr_i == `OFF_COMPARE_HI)
                compare_shadow[15:8] <= wdata_i;
            // R11 R12: write one clears; a new event wins
            counter_irq_flags[`BIT_OVERFLOW] <= overflow_hit ||
                (counter_irq_flags[`BIT_OVERFLOW] &&
                 !(wr_i && addr_i == `OFF_COUNTER_IRQ_FLAGS && wdata_i[`BIT_OVERFLOW]));
            counter_irq_flags[`BIT_COMPARE] <= compare_hit ||
                (counter_irq_flags[`BIT_COMPARE] &&
                 !(wr_i && addr_i == `OFF_COUNTER_IRQ_FLAGS && wdata_i[`BIT_COMPARE]));
            periodic_irq_flag <= periodic_rise ||
                (periodic_irq_flag &&
                 !(wr_i && addr_i == `OFF_PERIODIC_IRQ_FLAGS && wdata_i[0]));
        end
    end

    // R12: request held while flag and enable both set
    assign counter_irq_o = |(counter_irq_flags & counter_irq_enables);
    assign periodic_irq_o = periodic_irq_flag && periodic_irq_enable;

    ////////////////////////////////////////////////////////////////////////////
    // Sync into the real-time domain

    // R16 R26: write lands after two real-time edges
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_pend <= 5'h00;
            sync_age <= 2'h0;
        end else if (|{hit_cmp, hit_per, hit_cnt, hit_ctrl, hit_pctrl}) begin
            sync_pend <= sync_pend | {hit_cmp, hit_per, hit_cnt, hit_ctrl, hit_pctrl};
            sync_age <= 2'h0;
        end else if (rtc_edge && |sync_pend) begin
            if (sync_age == `SYNC_RTC_CYCLES - 1) begin
                sync_pend <= 5'h00;
                sync_age <= 2'h0;
            end else begin
                sync_age <= sync_age + 2'h1;
            end
        end
    end

    wire sync_land = rtc_edge && |sync_pend && (sync_age == `SYNC_RTC_CYCLES - 1);

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rt_counter_enable <= 1'b0;
            rt_run_in_standby <= 1'b0;
            rt_prescaler_sel <= 4'h0;
            rt_period <= `RESET_PERIOD_VALUE;
            rt_compare <= 16'h0000;
            rt_periodic_enable <= 1'b0;
            rt_periodic_sel <= 4'h0;
        end else if (sync_land) begin
            if (sync_pend[1]) begin
                rt_counter_enable <= counter_enable;
                rt_run_in_standby <= run_in_standby;
                rt_prescaler_sel <= prescaler_sel;
            end
            // R2: periodic enable lands on its own
            if (sync_pend[0]) begin
                rt_periodic_enable <= periodic_timer_enable;
                rt_periodic_sel <= periodic_sel;
            end
            if (sync_pend[3])
                rt_period <= period_shadow;
            if (sync_pend[4])
                rt_compare <= compare_shadow;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared prescaler and counter

    reg [PRESCALE_BITS-1:0] prescale_count;
    reg [PRESCALE_BITS-1:0] prev_prescale;
    reg pit_halted;
    reg pit_prev_out;

    // R14 R20: counter gated by standby and debug halt
    wire counter_run = rt_counter_enable && !(standby_sleep_i && !rt_run_in_standby) &&
        !(debug_halt_i && !counter_debug_run);
    // R15: periodic timer ignores sleep
    wire pit_halt_now = debug_halt_i && !periodic_debug_run;

    // R3 R4: prescaler runs while either function is on
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prescale_count <= {PRESCALE_BITS{1'b0}};
            prev_prescale <= {PRESCALE_BITS{1'b0}};
        end else if (rtc_edge && (rt_counter_enable || rt_periodic_enable)) begin
            prev_prescale <= prescale_count;
            prescale_count <= prescale_count + {{(PRESCALE_BITS-1){1'b0}}, 1'b1};
        end
    end

    // R25 R5: tick on prescaler low bits all ones
    wire [PRESCALE_BITS:0] wrap_mask = ({{PRESCALE_BITS{1'b0}}, 1'b1} << rt_prescaler_sel) -
        {{PRESCALE_BITS{1'b0}}, 1'b1};
    wire counter_tick = rtc_edge && (rt_counter_enable || rt_periodic_enable) &&
        ((prescale_count & wrap_mask[PRESCALE_BITS-1:0]) == wrap_mask[PRESCALE_BITS-1:0]);

    // R8 R9 R23: hit on the tick after equality
    assign overflow_hit = counter_tick && counter_run && (count_value == rt_period);
    assign compare_hit = counter_tick && counter_run && (count_value == rt_compare);

    // R27 R1: count while running; written count lands on sync
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_value <= 16'h0000;
        end else if (sync_land && sync_pend[2]) begin
            count_value <= count_shadow;
        end else if (overflow_hit) begin
            count_value <= 16'h0000;
        end else if (counter_tick && counter_run) begin
            count_value <= count_value + 16'h0001;
        end
    end

    // R7: events last one real-time clock period
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            overflow_event_o <= 1'b0;
            compare_event_o <= 1'b0;
        end else if (overflow_hit || compare_hit) begin
            overflow_event_o <= overflow_hit;
            compare_event_o <= compare_hit;
        end else if (rtc_edge) begin
            overflow_event_o <= 1'b0;
            compare_event_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Periodic timer

    // R24 R10 R6: output is prescaler bit code
    wire [3:0] pit_bit = (rt_periodic_sel < `PIT_CODE_MIN) ? `PIT_CODE_MIN :
        ((rt_periodic_sel > `PIT_CODE_MAX) ? `PIT_CODE_MAX : rt_periodic_sel);
    wire pit_raw = rt_periodic_enable && prescale_count[pit_bit];
    wire pit_had_prev = rt_periodic_enable && prev_prescale[pit_bit];

    // R21: forced low in halt without debug-run
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            periodic_out_o <= 1'b0;
            pit_halted <= 1'b0;
            pit_prev_out <= 1'b0;
        end else begin
            pit_halted <= pit_halt_now;
            pit_prev_out <= periodic_out_o;
            periodic_out_o <= pit_raw && !pit_halt_now;
        end
    end

    // R22: every output rise sets the flag
    assign periodic_rise = periodic_out_o && !pit_prev_out && !pit_halted;

    ////////////////////////////////////////////////////////////////////////////
    // Register reads

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= `RESET_BYTE;
            count_hi_latch <= `RESET_BYTE;
        end else if (rd_i) begin
            if (addr_i == `OFF_COUNTER_CONTROL)
                rdata_o <= {run_in_standby, prescaler_sel, 2'b00, counter_enable};
            // R17: busy while synchronizing
            else if (addr_i == `OFF_SYNC_STATUS)
                rdata_o <= {4'h0, sync_pend[4:1]};
            else if (addr_i == `OFF_COUNTER_IRQ_ENABLES)
                rdata_o <= {6'h00, counter_irq_enables};
            else if (addr_i == `OFF_COUNTER_IRQ_FLAGS)
                rdata_o <= {6'h00, counter_irq_flags};
            else if (addr_i == `OFF_COUNTER_DEBUG)
                rdata_o <= {7'h00, counter_debug_run};
            else if (addr_i == `OFF_COUNT_LO) begin
                rdata_o <= count_value[7:0];
                count_hi_latch <= count_value[15:8];
            end else if (addr_i == `OFF_COUNT_HI)
                rdata_o <= count_hi_latch;
            else if (addr_i == `OFF_PERIOD_LO)
                rdata_o <= period_shadow[7:0];
            else if (addr_i == `OFF_PERIOD_HI)
                rdata_o <= period_shadow[15:8];
            else if (addr_i == `OFF_COMPARE_LO)
                rdata_o <= compare_shadow[7:0];
            else if (addr_i == `OFF_COMPARE_HI)
                rdata_o <= compare_shadow[15:8];
            else if (addr_i == `OFF_PERIODIC_CONTROL)
                rdata_o <= {1'b0, periodic_sel, 2'b00, periodic_timer_enable};
            // R18: periodic control busy
            else if (addr_i == `OFF_PERIODIC_SYNC_STATUS)
                rdata_o <= {7'h00, sync_pend[0]};
            else if (addr_i == `OFF_PERIODIC_IRQ_ENABLES)
                rdata_o <= {7'h00, periodic_irq_enable};
            else if (addr_i == `OFF_PERIODIC_IRQ_FLAGS)
                rdata_o <= {7'h00, periodic_irq_flag};
            else if (addr_i == `OFF_PERIODIC_DEBUG)
                rdata_o <= {7'h00, periodic_debug_run};
            else
                rdata_o <= `RESET_BYTE;
        end else begin
            rdata_o <= `RESET_BYTE;
        end
    end

    wire unused_ok = &{1'b0, pit_had_prev, idle_sleep_i};

endmodule // rtc_periodic_interrupt_timer

`default_nettype wire

// *** sim/rtc_far_side.sv ***
// Purpose: Real-time clock and event sink.
// Assumes: Clock runs free.
// Notes: Overflow pulses in system cycles.
`timescale 1ns/1ps
`default_nettype none
module rtc_far_side #(
    parameter int HALF_NS = 64
) (
    input wire logic sys_clk_i,
    input wire logic overflow_event_i,
    output var logic rtc_clk_o,
    output var int ovf_width,
    output var int ovf_count
);
    int run = 0;
    initial begin
        rtc_clk_o = 1'b0;
        ovf_width = 0;
        ovf_count = 0;
        #3;
        forever #(HALF_NS) rtc_clk_o = ~rtc_clk_o;
    end
    always @(posedge sys_clk_i) begin
        if (overflow_event_i === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            ovf_width <= run;
            ovf_count <= ovf_count + 1;
            run <= 0;
        end
    end
endmodule // rtc_far_side
`default_nettype wire

// *** sim/rtc_periodic_interrupt_timer_tb_top.sv ***
// Purpose: Register tests of counter and periodic timer.
// Assumes: Real-time period is 32 system cycles.
// Notes: Intervals run rise to rise.
`include "rtc_pit_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module rtc_periodic_interrupt_timer_tb_top;
    logic sys_clk_i, reset_n_i = 0, wr_i = 0, rd_i = 0, debug_halt_i = 0;
    logic idle_sleep_i = 0, standby_sleep_i = 0;
    logic [4:0] addr_i = 5'h00;
    logic [7:0] wdata_i = 8'h00;
    wire [7:0] rdata_o;
    wire counter_irq_o, periodic_irq_o, overflow_event_o, compare_event_o, periodic_out_o, rtc_clk;
    int miscompares = 0, checked = 0, ovf_width, ovf_count, g, i, c;
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    rtc_periodic_interrupt_timer #(.PRESCALE_BITS(15)) DUT (.sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i), .rtc_clk_pin_i(rtc_clk), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .idle_sleep_i(idle_sleep_i), .standby_sleep_i(standby_sleep_i),
        .debug_halt_i(debug_halt_i), .rdata_o(rdata_o), .counter_irq_o(counter_irq_o),
        .periodic_irq_o(periodic_irq_o), .overflow_event_o(overflow_event_o),
        .compare_event_o(compare_event_o), .periodic_out_o(periodic_out_o));
    rtc_far_side #(.HALF_NS(64)) far (.sys_clk_i(sys_clk_i), .overflow_event_i(overflow_event_o),
        .rtc_clk_o(rtc_clk), .ovf_width(ovf_width), .ovf_count(ovf_count));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rc(input logic [4:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 check({8'h00, rdata_o}, {8'h00, e});
    endtask
    task automatic wait_idle;
        logic [7:0] busy;
        for (int n = 0; n < 100; n++) begin
            @(posedge sys_clk_i);
            rd_i <= 1'b1;
            addr_i <= `OFF_SYNC_STATUS;
            @(posedge sys_clk_i);
            addr_i <= `OFF_PERIODIC_SYNC_STATUS;
            #1 busy = rdata_o;
            @(posedge sys_clk_i);
            rd_i <= 1'b0;
            #1 if ((busy | rdata_o) === 8'h00) return;
        end
        check(16'h0001, 16'h0000);
    endtask
    function automatic logic pick(input int w);
        return w == 0 ? overflow_event_o : (w == 1 ? compare_event_o : periodic_out_o);
    endfunction
    task automatic edge_of(input int w, output int n);
        n = 0;
        while (pick(w) !== 1'b0 && n < 20000) begin
            @(posedge sys_clk_i);
            n++;
        end
        while (pick(w) !== 1'b1 && n < 20000) begin
            @(posedge sys_clk_i);
            n++;
        end
    endtask
    task automatic finish_test;
        if (miscompares == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        wait_idle();
        wr(5'h04, 8'hFF);
        for (i = 0; i < 32; i++) rc(i[4:0], (i == 10 || i == 11) ? 8'hFF : 8'h00);
        wr(`OFF_COMPARE_LO, 8'h03);
        rc(`OFF_SYNC_STATUS, 8'h08);
        wait_idle();
        wr(`OFF_PERIOD_LO, 8'h05);
        rc(`OFF_SYNC_STATUS, 8'h04);
        wait_idle();
        wr(`OFF_PERIOD_HI, 8'h00);
        wait_idle();
        wr(`OFF_PERIODIC_CONTROL, 8'h08);
        rc(`OFF_PERIODIC_SYNC_STATUS, 8'h01);
        wait_idle();
        wr(`OFF_COUNTER_IRQ_ENABLES, 8'h03);
        idle_sleep_i <= 1'b1;
        for (i = 0; i < 3; i++) begin
            wr(`OFF_COUNTER_CONTROL, {1'b0, i[3:0], 3'b001});
            rc(`OFF_SYNC_STATUS, 8'h01);
            wait_idle();
            edge_of(0, g);
            edge_of(0, g);
            check(16'(g), 16'(192 << i));
            edge_of(1, g);
            edge_of(0, g);
            check(16'(g), 16'(64 << i));
        end
        idle_sleep_i <= 1'b0;
        check(16'(ovf_width), 16'd32);
        check(counter_irq_o, 1'b1);
        rc(`OFF_COUNTER_IRQ_FLAGS, 8'h03);
        wr(`OFF_COUNTER_IRQ_ENABLES, 8'h00);
        check(counter_irq_o, 1'b0);
        wr(`OFF_COUNTER_IRQ_ENABLES, 8'h03);
        check(counter_irq_o, 1'b1);
        wr(`OFF_COUNTER_CONTROL, 8'h00);
        wait_idle();
        wr(`OFF_COUNTER_IRQ_FLAGS, 8'h01);
        rc(`OFF_COUNTER_IRQ_FLAGS, 8'h02);
        wr(`OFF_COUNTER_IRQ_FLAGS, 8'h02);
        check(counter_irq_o, 1'b0);
        wr(`OFF_COUNT_LO, 8'h34);
        rc(`OFF_SYNC_STATUS, 8'h02);
        wait_idle();
        wr(`OFF_COUNT_HI, 8'h12);
        wait_idle();
        repeat (300) @(posedge sys_clk_i);
        rc(`OFF_COUNT_LO, 8'h34);
        rc(`OFF_COUNT_HI, 8'h12);
        wr(`OFF_COUNT_HI, 8'h00);
        wait_idle();
        wr(`OFF_COUNT_LO, 8'h00);
        wait_idle();
        wr(`OFF_COUNTER_CONTROL, 8'h01);
        wait_idle();
        standby_sleep_i <= 1'b1;
        repeat (100) @(posedge sys_clk_i);
        c = ovf_count;
        wr(`OFF_PERIODIC_CONTROL, 8'h09);
        wait_idle();
        edge_of(2, g);
        edge_of(2, g);
        check(16'(g), 16'd128);
        check(16'(ovf_count), 16'(c));
        wr(`OFF_PERIODIC_IRQ_ENABLES, 8'h01);
        rc(`OFF_PERIODIC_IRQ_FLAGS, 8'h01);
        check(periodic_irq_o, 1'b1);
        wr(`OFF_COUNTER_CONTROL, 8'h81);
        wait_idle();
        edge_of(0, g);
        edge_of(0, g);
        check(16'(g), 16'd192);
        standby_sleep_i <= 1'b0;
        for (i = 1; i < 4; i++) begin
            wr(`OFF_PERIODIC_CONTROL, {1'b0, i[3:0], 3'b001});
            wait_idle();
            edge_of(2, g);
            edge_of(2, g);
            check(16'(g), 16'(64 << i));
        end
        debug_halt_i <= 1'b1;
        repeat (40) @(posedge sys_clk_i);
        c = ovf_count;
        repeat (360) @(posedge sys_clk_i);
        check(periodic_out_o, 1'b0);
        check(16'(ovf_count), 16'(c));
        debug_halt_i <= 1'b0;
        edge_of(2, g);
        wr(`OFF_PERIODIC_IRQ_FLAGS, 8'h01);
        debug_halt_i <= 1'b1;
        repeat (100) @(posedge sys_clk_i);
        check(periodic_out_o, 1'b0);
        debug_halt_i <= 1'b0;
        repeat (100) @(posedge sys_clk_i);
        rc(`OFF_PERIODIC_IRQ_FLAGS, 8'h01);
        wr(`OFF_PERIODIC_DEBUG, 8'h01);
        wr(`OFF_COUNTER_DEBUG, 8'h01);
        debug_halt_i <= 1'b1;
        edge_of(0, g);
        edge_of(0, g);
        check(16'(g), 16'd192);
        edge_of(2, g);
        edge_of(2, g);
        check(16'(g), 16'd512);
        debug_halt_i <= 1'b0;
        finish_test();
    end
endmodule // rtc_periodic_interrupt_timer_tb_top
`default_nettype wire

// *** sim/rtc_pit_checker_properties.sv ***
// Purpose: Port checks of counter and periodic timer.
// Assumes: Slow real-time pin.
// Notes: Some control bits shadow bus writes.
`include "rtc_pit_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module rtc_pit_checker (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic rtc_clk_pin_i,
    input wire logic [4:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic standby_sleep_i,
    input wire logic debug_halt_i,
    input wire logic counter_irq_o,
    input wire logic periodic_irq_o,
    input wire logic overflow_event_o,
    input wire logic compare_event_o,
    input wire logic periodic_out_o
);
    logic stdby_ok, pit_dbg, pin_q;
    logic [7:0] since_rise, halt_cnt, sb_cnt;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {stdby_ok, pit_dbg, pin_q} <= 3'h0;
            {since_rise, halt_cnt, sb_cnt} <= 24'h000000;
        end else begin
            pin_q <= rtc_clk_pin_i;
            if (wr_i && addr_i == `OFF_COUNTER_CONTROL) stdby_ok <= wdata_i[7];
            if (wr_i && addr_i == `OFF_PERIODIC_DEBUG) pit_dbg <= wdata_i[0];
            since_rise <= (rtc_clk_pin_i && !pin_q) ? 8'h00 : since_rise + (since_rise != 8'hFF);
            halt_cnt <= (debug_halt_i && !pit_dbg) ? halt_cnt + (halt_cnt != 8'hFF) : 8'h00;
            sb_cnt <= standby_sleep_i ? sb_cnt + (sb_cnt != 8'hFF) : 8'h00;
        end
    end
    cnt_irq_hold_a: assert property ($fell(counter_irq_o) |-> $past(wr_i) &&
        ($past(addr_i) inside {`OFF_COUNTER_IRQ_FLAGS, `OFF_COUNTER_IRQ_ENABLES}))
        else $error("counter request dropped");
    pit_irq_hold_a: assert property ($fell(periodic_irq_o) |-> $past(wr_i) &&
        ($past(addr_i) inside {`OFF_PERIODIC_IRQ_FLAGS, `OFF_PERIODIC_IRQ_ENABLES}))
        else $error("periodic request dropped");
    pit_irq_cause_a: assert property ($rose(periodic_irq_o) |-> $past(periodic_out_o) || $past(wr_i))
        else $error("periodic request uncaused");
    cnt_irq_cause_a: assert property ($rose(counter_irq_o) |-> overflow_event_o || compare_event_o || $past(wr_i))
        else $error("counter request uncaused");
    ovf_pulse_len_a: assert property ($rose(overflow_event_o) |-> overflow_event_o[*8] ##[1:40] !overflow_event_o)
        else $error("overflow pulse length");
    cmp_pulse_len_a: assert property ($rose(compare_event_o) |=> compare_event_o[*7] ##[1:40] $fell(compare_event_o))
        else $error("compare pulse length");
    event_on_tick_a: assert property ($rose(overflow_event_o) || $rose(compare_event_o) |-> since_rise < 8'h08)
        else $error("event off real-time edge");
    pit_debug_low_a: assert property (halt_cnt >= 8'hA0 |-> !periodic_out_o)
        else $error("periodic high in halt");
    standby_stop_a: assert property ($rose(overflow_event_o) |-> sb_cnt < 8'hA0 || stdby_ok)
        else $error("counter ran in standby");
    cover property ($rose(overflow_event_o));
    cover property ($rose(periodic_irq_o));
    cover property (halt_cnt == 8'hFF);
endmodule // rtc_pit_checker
bind rtc_periodic_interrupt_timer rtc_pit_checker u_chk (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .rtc_clk_pin_i(rtc_clk_pin_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .standby_sleep_i(standby_sleep_i), .debug_halt_i(debug_halt_i),
    .counter_irq_o(counter_irq_o), .periodic_irq_o(periodic_irq_o),
    .overflow_event_o(overflow_event_o), .compare_event_o(compare_event_o),
    .periodic_out_o(periodic_out_o));
`default_nettype wire
